/* File: pkg/usb_bulk_in_pkg.sv */
// Constants, state codes and helpers for the Bulk In frame encapsulator.
// Assumes one device clock shared by all blocks and one synchronous reset used by all but the word RAMs.
//
// Function
// R01: Payload buffer is 2K by 32-bit words.
// R02: Packets and frames start on word boundaries.
// R03: Multi-frame mode never shares a word between frames.
// R04: Non-final frame filler bytes count in length.
// R05: Transfer end excludes unused trailing bytes.
// R06: Device core drops bytes beyond reported length.
// R07: Every packet length, zero included, is queued.
// R08: Length queue holds up to 32 entries.
// R09: Length queue signals full; no write then.
// R10: Head length and entry count go out.
// R11: Length and count valid when transmission starts.
// R12: Mode bit: set multi-frame, clear single-frame.
// R13: Multi-frame mode packs consecutive frames together.
// R14: Single-frame mode holds one frame per packet.
// R15: Long frames split over several packets.
// R16: Three command words precede frame; first gives length.
// R17: Buffer frames to sustain 4 Gbps bursts.
// R18: Filler only when another frame is ready.
// R19: Filler bytes excluded from frame length word.
// R20: Burst ends short or with zero-length packet.
// R21: Stall input when buffer or queue full.
// R22: Free space only after packet reported sent.
package usb_bulk_in_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int WORD_W        = 32;
  localparam int DATA_DEPTH    = 2048;
  localparam int DATA_AW       = 11;
  localparam int PTR_W         = 12;
  localparam int CMD_DEPTH     = 32;
  localparam int CMD_AW        = 5;
  localparam int CNT_W         = 6;
  localparam int LEN_W         = 11;
  localparam int FLEN_W        = 14;
  localparam int FLEN_LSB      = 0;
  localparam int WORDS_W       = 13;
  localparam int IN_FIFO_DEPTH = 8;
  localparam int IN_FIFO_AW    = 3;
  localparam int CMD_WORDS     = 3;

  // Throughput: one word per clock gives 6400 Mbps, above the 4000 Mbps line rate
  localparam int CLOCK_MHZ      = 200;
  localparam int LINE_RATE_MBPS = 4000;

  // ****************************************************************
  // Codes and limits
  // ****************************************************************
  localparam logic [1:0]       SPEED_FS       = 2'h0;
  localparam logic [1:0]       SPEED_HS       = 2'h1;
  localparam logic [1:0]       SPEED_SS       = 2'h2;
  localparam logic [LEN_W-1:0] MAXP_FS        = 11'h040;
  localparam logic [LEN_W-1:0] MAXP_HS        = 11'h200;
  localparam logic [LEN_W-1:0] MAXP_SS        = 11'h400;
  localparam logic [LEN_W-1:0] WORD_BYTES     = 11'h004;
  localparam logic [PTR_W-1:0] DATA_FULL_USED = 12'h800;
  localparam logic [CNT_W-1:0] CMD_FULL_COUNT = 6'h20;

  typedef enum logic [2:0] {
    ST_HEAD = 3'b001,
    ST_BODY = 3'b010,
    ST_ZLP  = 3'b100
  } state_type;

  // Whole words needed for a byte count
  function automatic logic [WORDS_W-1:0] words_of(input logic [FLEN_W-1:0] len);
    logic [FLEN_W:0] tmp;
    tmp      = {1'b0, len} + 15'h0003;
    words_of = tmp[FLEN_W:2];
  endfunction

endpackage

/* File: rtl/word_ram.sv */
// Simple dual-port word memory with registered read data.
// Assumes reads of an address written in the same cycle return old data.
`timescale 1ns/10ps
module word_ram #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2048,
  parameter int AW    = 11
) (
  input  wire logic             clock,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

/* File: rtl/stream_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
// Assumes a single clock; input ready comes from a register.
`timescale 1ns/10ps
module stream_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [AW:0]      level
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_level;
  logic             next_in_ready;
  logic             push;
  logic             pop;

  always_comb begin
    push          = in_valid && in_ready;
    pop           = out_valid && out_ready;
    next_wr_ptr   = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr   = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_level    = level + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    next_in_ready = next_level != (AW+1)'(DEPTH);
    out_valid     = level != '0;
    out_data      = mem[rd_ptr];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      level    <= '0;
      in_ready <= 1'b0;
    end else begin
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      level    <= next_level;
      in_ready <= next_in_ready;
    end
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule

/* File: rtl/bulk_in_transmitter.sv */
// Bulk In encapsulator: packs received frames into USB packets, keeps
// payload in a word buffer and packet lengths in a length queue.
// Assumes the frame FIFO controller and the device core share this clock.
`timescale 1ns/10ps
module bulk_in_transmitter (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        multi_frame_packing,
  input  wire logic [1:0]  speed,
  input  wire logic [31:0] rx_data,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic        tx_rd,
  output logic      [31:0] tx_data,
  output logic      [10:0] pkt_len,
  output logic      [5:0]  pkt_avail,
  output logic             cmd_full,
  input  wire logic        pkt_sent,
  input  wire logic        rewind
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  usb_bulk_in_pkg::state_type                 state;
  usb_bulk_in_pkg::state_type                 next_state;
  logic [usb_bulk_in_pkg::WORDS_W-1:0]        words_left;
  logic [usb_bulk_in_pkg::WORDS_W-1:0]        next_words_left;
  logic [2:0]                                 last_rem;
  logic [2:0]                                 next_last_rem;
  logic [usb_bulk_in_pkg::LEN_W-1:0]          pkt_bytes;
  logic [usb_bulk_in_pkg::LEN_W-1:0]          next_pkt_bytes;
  logic [usb_bulk_in_pkg::LEN_W-1:0]          add;
  logic [usb_bulk_in_pkg::LEN_W-1:0]          sum;
  logic [usb_bulk_in_pkg::LEN_W-1:0]          maxp;
  logic                                       cmd_we;
  logic [usb_bulk_in_pkg::LEN_W-1:0]          cmd_wdata;

  logic [31:0]                                f_data;
  logic                                       f_valid;
  logic [usb_bulk_in_pkg::IN_FIFO_AW:0]       f_level;
  logic                                       take;
  logic                                       last_word;
  logic                                       pad;
  logic [usb_bulk_in_pkg::FLEN_W-1:0]         frame_len;

  logic [usb_bulk_in_pkg::PTR_W-1:0]          data_wr_ptr;
  logic [usb_bulk_in_pkg::PTR_W-1:0]          rel_ptr;
  logic [usb_bulk_in_pkg::PTR_W-1:0]          rd_ptr;
  logic [usb_bulk_in_pkg::PTR_W-1:0]          next_data_wr_ptr;
  logic [usb_bulk_in_pkg::PTR_W-1:0]          next_rel_ptr;
  logic [usb_bulk_in_pkg::PTR_W-1:0]          next_rd_ptr;
  logic [usb_bulk_in_pkg::PTR_W-1:0]          used;
  logic                                       room;
  logic [usb_bulk_in_pkg::CNT_W-1:0]          cmd_wr_ptr;
  logic [usb_bulk_in_pkg::CNT_W-1:0]          cmd_rd_ptr;
  logic [usb_bulk_in_pkg::CNT_W-1:0]          cmd_count;
  logic [usb_bulk_in_pkg::CNT_W-1:0]          next_cmd_wr_ptr;
  logic [usb_bulk_in_pkg::CNT_W-1:0]          next_cmd_rd_ptr;
  logic [usb_bulk_in_pkg::CNT_W-1:0]          next_cmd_count;
  logic                                       cmd_at_full;
  logic                                       pop;
  logic [usb_bulk_in_pkg::WORDS_W-1:0]        free_words;

  logic [usb_bulk_in_pkg::LEN_W-1:0]          cmd_q;
  logic                                       bypass;
  logic                                       next_bypass;
  logic [usb_bulk_in_pkg::LEN_W-1:0]          bypass_data;
  logic [usb_bulk_in_pkg::LEN_W-1:0]          next_bypass_data;
  logic [usb_bulk_in_pkg::LEN_W-1:0]          next_pkt_len;
  logic [usb_bulk_in_pkg::CNT_W-1:0]          next_pkt_avail;
  logic                                       next_cmd_full;

  // ****************************************************************
  // Input buffering
  // ****************************************************************
  // Eight words of slack decouple the controller from buffer stalls,
  // and the fill level tells whether another frame already waits.
  stream_fifo #(
    .WIDTH (usb_bulk_in_pkg::WORD_W),
    .DEPTH (usb_bulk_in_pkg::IN_FIFO_DEPTH),
    .AW    (usb_bulk_in_pkg::IN_FIFO_AW)
  ) in_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_data   (rx_data),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (take),
    .level     (f_level)
  );

  // ****************************************************************
  // Packet builder
  // ****************************************************************
  always_comb begin
    case (speed)
      usb_bulk_in_pkg::SPEED_SS: maxp = usb_bulk_in_pkg::MAXP_SS;
      usb_bulk_in_pkg::SPEED_HS: maxp = usb_bulk_in_pkg::MAXP_HS;
      default:                   maxp = usb_bulk_in_pkg::MAXP_FS;
    endcase
  end

  always_comb begin
    used        = data_wr_ptr - rel_ptr;
    room        = used != usb_bulk_in_pkg::DATA_FULL_USED;             // [R01]
    cmd_at_full = cmd_count == usb_bulk_in_pkg::CMD_FULL_COUNT;          // [R08]
    // Stalling on a full queue for every word is simpler than predicting
    // which word closes a packet, at the cost of a little throughput.
    take        = (state != usb_bulk_in_pkg::ST_ZLP) && f_valid && room
                  && !cmd_at_full;                                       // [R21] [R17]
    frame_len   = f_data[usb_bulk_in_pkg::FLEN_LSB +: usb_bulk_in_pkg::FLEN_W]; // [R16]
    last_word   = words_left == 13'h0001;
    // Filler only when the next frame's first word is already queued
    pad         = multi_frame_packing && (f_level > 4'h1);               // [R12] [R18]
  end

  always_comb begin
    next_state      = state;
    next_words_left = words_left;
    next_last_rem   = last_rem;
    next_pkt_bytes  = pkt_bytes;
    cmd_we          = 1'b0;
    cmd_wdata       = '0;
    add             = usb_bulk_in_pkg::WORD_BYTES;
    sum             = '0;
    case (state)
      usb_bulk_in_pkg::ST_HEAD: begin
        if (take) begin
          // Length word plus two more command words, then the payload
          next_words_left = usb_bulk_in_pkg::WORDS_W'(usb_bulk_in_pkg::CMD_WORDS - 1)
                            + usb_bulk_in_pkg::words_of(frame_len);      // [R16]
          next_last_rem   = (frame_len[1:0] == 2'h0) ? 3'h4 : {1'b0, frame_len[1:0]};
          sum             = pkt_bytes + add;
          if (sum == maxp) begin
            cmd_we         = 1'b1;                                       // [R15] [R07]
            cmd_wdata      = sum;
            next_pkt_bytes = '0;
          end else begin
            next_pkt_bytes = sum;
          end
          next_state = usb_bulk_in_pkg::ST_BODY;
        end
      end
      usb_bulk_in_pkg::ST_BODY: begin
        if (take) begin
          // A padded last word counts four bytes, a closing one only its own
          if (last_word && !pad) begin
            add = {8'h00, last_rem};                                     // [R05] [R06]
          end
          sum             = pkt_bytes + add;                             // [R04] [R19]
          next_words_left = words_left - 13'h0001;
          if (last_word) begin
            next_state = usb_bulk_in_pkg::ST_HEAD;                       // [R02] [R03]
          end
          if ((sum == maxp) || (last_word && !pad)) begin
            cmd_we         = 1'b1;                                       // [R07] [R14] [R15]
            cmd_wdata      = sum;
            next_pkt_bytes = '0;
          end else begin
            next_pkt_bytes = sum;                                        // [R13]
          end
          if (last_word && !pad && (sum == maxp)) begin
            next_state = usb_bulk_in_pkg::ST_ZLP;                        // [R20]
          end
        end
      end
      usb_bulk_in_pkg::ST_ZLP: begin
        if (!cmd_at_full) begin
          cmd_we     = 1'b1;                                             // [R20] [R09]
          cmd_wdata  = '0;
          next_state = usb_bulk_in_pkg::ST_HEAD;
        end
      end
      default: begin
        next_state = usb_bulk_in_pkg::ST_HEAD;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state      <= usb_bulk_in_pkg::ST_HEAD;
      words_left <= '0;
      last_rem   <= 3'h4;
      pkt_bytes  <= '0;
    end else begin
      state      <= next_state;
      words_left <= next_words_left;
      last_rem   <= next_last_rem;
      pkt_bytes  <= next_pkt_bytes;
    end
  end

  // ****************************************************************
  // Buffer and queue pointers
  // ****************************************************************
  always_comb begin
    pop              = pkt_sent && (pkt_avail != '0);                     // [R22]
    next_data_wr_ptr = take ? data_wr_ptr + 12'h001 : data_wr_ptr;
    // A zero-length packet frees no words
    free_words       = usb_bulk_in_pkg::words_of({3'h0, pkt_len});
    next_rel_ptr     = pop ? rel_ptr + free_words[usb_bulk_in_pkg::PTR_W-1:0]
                           : rel_ptr;                                    // [R22]
    if (rewind) begin
      next_rd_ptr = next_rel_ptr;
    end else if (tx_rd) begin
      next_rd_ptr = rd_ptr + 12'h001;
    end else begin
      next_rd_ptr = rd_ptr;
    end
    next_cmd_wr_ptr  = cmd_we ? cmd_wr_ptr + 6'h01 : cmd_wr_ptr;
    next_cmd_rd_ptr  = pop ? cmd_rd_ptr + 6'h01 : cmd_rd_ptr;
    next_cmd_count   = cmd_count + {5'h00, cmd_we} - {5'h00, pop};
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      data_wr_ptr <= '0;
      rel_ptr     <= '0;
      rd_ptr      <= '0;
      cmd_wr_ptr  <= '0;
      cmd_rd_ptr  <= '0;
      cmd_count   <= '0;
    end else begin
      data_wr_ptr <= next_data_wr_ptr;
      rel_ptr     <= next_rel_ptr;
      rd_ptr      <= next_rd_ptr;
      cmd_wr_ptr  <= next_cmd_wr_ptr;
      cmd_rd_ptr  <= next_cmd_rd_ptr;
      cmd_count   <= next_cmd_count;
    end
  end

  // ****************************************************************
  // Memories
  // ****************************************************************
  word_ram #(
    .WIDTH (usb_bulk_in_pkg::WORD_W),
    .DEPTH (usb_bulk_in_pkg::DATA_DEPTH),
    .AW    (usb_bulk_in_pkg::DATA_AW)
  ) data_ram (
    .clock   (clock),
    .wr_en   (take),
    .wr_addr (data_wr_ptr[usb_bulk_in_pkg::DATA_AW-1:0]),
    .wr_data (f_data),
    .rd_addr (rd_ptr[usb_bulk_in_pkg::DATA_AW-1:0]),
    .rd_data (tx_data)
  );

  word_ram #(
    .WIDTH (usb_bulk_in_pkg::LEN_W),
    .DEPTH (usb_bulk_in_pkg::CMD_DEPTH),
    .AW    (usb_bulk_in_pkg::CMD_AW)
  ) cmd_ram (
    .clock   (clock),
    .wr_en   (cmd_we),
    .wr_addr (cmd_wr_ptr[usb_bulk_in_pkg::CMD_AW-1:0]),
    .wr_data (cmd_wdata),
    .rd_addr (next_cmd_rd_ptr[usb_bulk_in_pkg::CMD_AW-1:0]),
    .rd_data (cmd_q)
  );

  // ****************************************************************
  // Device core view
  // ****************************************************************
  // The length RAM returns old data when the head slot is written in
  // the same cycle, so that write is forwarded around it.
  always_comb begin
    next_bypass      = cmd_we && (cmd_wr_ptr[usb_bulk_in_pkg::CMD_AW-1:0]
                       == next_cmd_rd_ptr[usb_bulk_in_pkg::CMD_AW-1:0]);
    next_bypass_data = cmd_wdata;
    next_pkt_len     = bypass ? bypass_data : cmd_q;                     // [R10]
    next_pkt_avail   = cmd_count;                                        // [R10] [R11]
    next_cmd_full    = next_cmd_count == usb_bulk_in_pkg::CMD_FULL_COUNT; // [R09]
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bypass      <= 1'b0;
      bypass_data <= '0;
      pkt_len     <= '0;
      pkt_avail   <= '0;
      cmd_full    <= 1'b0;
    end else begin
      bypass      <= next_bypass;
      bypass_data <= next_bypass_data;
      pkt_len     <= next_pkt_len;
      pkt_avail   <= next_pkt_avail;
      cmd_full    <= next_cmd_full;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  buffer_room_a: assert property (@(posedge clock) disable iff (rst) // [R01] [R21]
    take |-> (used != usb_bulk_in_pkg::DATA_FULL_USED) && !cmd_at_full)
    else $error("word taken while buffer or queue full");

  queue_bound_a: assert property (@(posedge clock) disable iff (rst) // [R08] [R09]
    cmd_at_full |=> (cmd_count != 6'h21))
    else $error("length queue overflowed");

  full_flag_a: assert property (@(posedge clock) disable iff (rst) // [R09]
    (cmd_count == 6'h20) |=> cmd_full || $past(pop))
    else $error("full flag missing");

  count_view_a: assert property (@(posedge clock) disable iff (rst) // [R10]
    (cmd_we && !pop) |-> ##2 (pkt_avail == $past(cmd_count, 2) + 6'h01))
    else $error("packet count not updated");

  head_length_a: assert property (@(posedge clock) disable iff (rst) // [R11]
    (cmd_we && (cmd_count == 6'h00)) |-> ##2 (pkt_len == $past(cmd_wdata, 2)))
    else $error("head length not presented");

  single_close_a: assert property (@(posedge clock) disable iff (rst) // [R14]
    (take && last_word && !multi_frame_packing
     && (state == usb_bulk_in_pkg::ST_BODY)) |-> cmd_we)
    else $error("frame end did not close packet");

  exact_end_a: assert property (@(posedge clock) disable iff (rst) // [R05]
    (take && last_word && !pad && (state == usb_bulk_in_pkg::ST_BODY))
    |-> (cmd_wdata == pkt_bytes + {8'h00, last_rem}))
    else $error("transfer end length wrong");

  zero_packet_a: assert property (@(posedge clock) disable iff (rst) // [R20]
    (cmd_we && (cmd_wdata == maxp) && (state == usb_bulk_in_pkg::ST_BODY)
     && last_word && !pad) |=> (state == usb_bulk_in_pkg::ST_ZLP) ##[0:40]
     (cmd_we && (cmd_wdata == 11'h000)))
    else $error("zero-length packet missing");

  release_sent_a: assert property (@(posedge clock) disable iff (rst) // [R22]
    (rel_ptr != $past(rel_ptr)) |-> $past(pkt_sent))
    else $error("space freed without sent report");

endmodule

/* File: testbench/device_core_model.sv */
// Behavioural model of the USB device core that drains the Bulk In queue.
// Assumes the encapsulator's clock; reads whole packets, then acknowledges.
`timescale 1ns/10ps
module device_core_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        enable,
  input  wire logic [10:0] pkt_len,
  input  wire logic [5:0]  pkt_avail,
  input  wire logic [31:0] tx_data,
  output logic             tx_rd,
  output logic             pkt_sent,
  output logic      [10:0] last_len,
  output logic      [31:0] sum,
  output logic      [7:0]  pkt_count
);
  logic [2:0] state;
  logic [8:0] left;
  logic       rd_q;

  // ****************************************************************
  // Read a packet word by word, then report it sent
  // ****************************************************************
  always_ff @(posedge clock) begin
    rd_q     <= tx_rd;
    pkt_sent <= 1'b0;
    if (rd_q) begin
      sum <= sum + tx_data;
    end
    if (rst) begin
      state     <= 3'h0;
      tx_rd     <= 1'b0;
      rd_q      <= 1'b0;
      sum       <= 32'h0;
      pkt_count <= 8'h0;
      last_len  <= 11'h0;
    end else begin
      case (state)
        3'h0: if (enable && pkt_avail != 6'h00) begin
          // Only whole words up to the length are fetched; the rest is dropped
          left     <= 9'((pkt_len + 11'h003) >> 2);
          last_len <= pkt_len;
          state    <= 3'h1;
        end
        3'h1: if (left == 9'h0) begin
          tx_rd <= 1'b0;
          state <= 3'h2;
        end else begin
          tx_rd <= 1'b1;
          left  <= left - 9'h1;
        end
        3'h2: if (!rd_q) begin
          // Acknowledge only after the last word went out
          pkt_sent  <= 1'b1;
          pkt_count <= pkt_count + 8'h1;
          state     <= 3'h3;
        end
        // Spacing so the next head length is fresh
        3'h3: state <= 3'h4;
        default: state <= 3'h0;
      endcase
    end
  end
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench: streams frames in, drains packets through the core model.
// Assumes one 200 MHz clock and a synchronous active-high reset.
`timescale 1ns/10ps
module tb_top;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        multi_frame_packing = 1'b0;
  logic [1:0]  speed = 2'h2;
  logic [31:0] rx_data = 32'h0;
  logic        rx_valid = 1'b0;
  logic        rewind = 1'b0;
  logic        enable = 1'b0;
  logic        rx_ready, tx_rd, cmd_full, pkt_sent;
  logic [31:0] tx_data, sum;
  logic [31:0] exp_sum = 32'h0;
  logic [10:0] pkt_len, last_len;
  logic [5:0]  pkt_avail;
  logic [7:0]  pkt_count;
  int          error_cnt = 0;
  int          total_checks = 0;

  initial begin
    forever #2.5 clock = ~clock;
  end

  bulk_in_transmitter dut (.clock(clock), .rst(rst), .multi_frame_packing(multi_frame_packing),
    .speed(speed), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_rd(tx_rd),
    .tx_data(tx_data), .pkt_len(pkt_len), .pkt_avail(pkt_avail), .cmd_full(cmd_full),
    .pkt_sent(pkt_sent), .rewind(rewind));

  device_core_model core (.clock(clock), .rst(rst), .enable(enable), .pkt_len(pkt_len),
    .pkt_avail(pkt_avail), .tx_data(tx_data), .tx_rd(tx_rd), .pkt_sent(pkt_sent),
    .last_len(last_len), .sum(sum), .pkt_count(pkt_count));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Held until a falling edge shows ready, so the next rising edge takes it
  task automatic send_word(input logic [31:0] w);
    int n;
    n = 0;
    @(negedge clock);
    rx_valid = 1'b1;
    rx_data  = w;
    while (rx_ready !== 1'b1 && n < 4000) begin
      n++;
      @(negedge clock);
    end
    if (n >= 4000) error_cnt++;
    @(posedge clock);
    exp_sum = exp_sum + w;
  endtask

  task automatic send_frame(input int len, input logic [7:0] tag);
    send_word(32'(len));
    send_word(32'h0000b000);
    send_word(32'h0000c000);
    for (int i = 0; i < (len + 3) / 4; i++) send_word({tag, 24'(i)});
  endtask

  task automatic idle;
    @(negedge clock);
    rx_valid = 1'b0;
  endtask

  task automatic wait_avail(input logic [5:0] n);
    int k;
    k = 0;
    while (pkt_avail !== n && k < 400) begin
      k++;
      @(negedge clock);
    end
    check("pkt_avail", 32'(n), 32'(pkt_avail));
  endtask

  task automatic drain(input logic [7:0] n);
    int k;
    k = 0;
    enable = 1'b1;
    while (pkt_count !== n && k < 8000) begin
      k++;
      @(negedge clock);
    end
    enable = 1'b0;
    check("packets", 32'(n), 32'(pkt_count));
    check("payload sum", exp_sum, sum);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_single;
    check("pkt_avail", 32'h0, 32'(pkt_avail));
    check("cmd_full", 32'h0, 32'(cmd_full));
    send_frame(5, 8'h11);
    idle;
    wait_avail(6'h01);
    check("pkt_len", 32'h11, 32'(pkt_len));
    drain(8'h01);
  endtask

  // The zero-length entry after the first frame stalls the builder a cycle,
  // so the next frame already waits behind the middle one, which is padded
  task automatic t_multi;
    multi_frame_packing = 1'b1;
    speed = 2'h0;
    send_frame(52, 8'h21);
    send_frame(5, 8'h22);
    send_frame(6, 8'h23);
    idle;
    wait_avail(6'h03);
    check("pkt_len", 32'h40, 32'(pkt_len));
    drain(8'h04);
    check("multi len", 32'h26, 32'(last_len));
    multi_frame_packing = 1'b0;
    speed = 2'h2;
  endtask

  task automatic t_exact;
    speed = 2'h0;
    send_frame(52, 8'h31);
    idle;
    wait_avail(6'h02);
    check("pkt_len", 32'h40, 32'(pkt_len));
    drain(8'h06);
    check("zlp len", 32'h0, 32'(last_len));
  endtask

  task automatic t_split;
    send_frame(100, 8'h41);
    idle;
    wait_avail(6'h02);
    check("pkt_len", 32'h40, 32'(pkt_len));
    drain(8'h08);
    check("tail len", 32'h30, 32'(last_len));
    speed = 2'h2;
  endtask

  // High speed: 12 command bytes plus 500 payload bytes fill one packet exactly
  task automatic t_high;
    speed = 2'h1;
    send_frame(500, 8'h51);
    idle;
    wait_avail(6'h02);
    check("pkt_len", 32'h200, 32'(pkt_len));
    drain(8'h0a);
    check("zlp len", 32'h0, 32'(last_len));
    speed = 2'h2;
  endtask

  // Queue fills before the buffer; eight more words only fill the input FIFO
  task automatic t_full;
    for (int i = 0; i < 34; i++) send_frame(4, 8'(i));
    idle;
    repeat (10) @(negedge clock);
    check("pkt_avail", 32'h20, 32'(pkt_avail));
    check("cmd_full", 32'h1, 32'(cmd_full));
    check("rx_ready", 32'h0, 32'(rx_ready));
    drain(8'h2c);
    check("cmd_full", 32'h0, 32'(cmd_full));
  endtask

  // ****************************************************************
  // Sequence and verdict
  // ****************************************************************
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    t_single;
    t_multi;
    t_exact;
    t_split;
    t_high;
    t_full;
    give_verdict;
  end

  // Whole run needs about a thousand cycles; this is far beyond that
  initial begin
    #300us;
    error_cnt++;
    give_verdict;
  end
endmodule
